// ---- iosld_top.v ----
`include "iosld_defines.vh"

// Terminal status formatter for the four-digit LED monitor.
module iosld_top #(
	parameter ADDR_W = 8
) (
	// Clock and reset.
	input wire clk_sys_in,
	input wire nrst_in,
	// APB slave.
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [ADDR_W-1:0] paddr_in,
	input wire [31:0] pwdata_in,
	output reg [31:0] prdata_out,
	output reg pready_out,
	output reg pslverr_out,
	// Control circuit terminals, high while closed or conducting.
	input wire forward_run_input_in,
	input wire reverse_run_input_in,
	input wire [4:0] general_digital_inputs_in,
	input wire first_transistor_output_in,
	input wire second_transistor_output_in,
	input wire alarm_relay_contact_in,
	// Digital I/O option card terminals.
	input wire [11:0] option_card_inputs_in,
	input wire option_card_select_in,
	input wire [7:0] option_card_outputs_in,
	// Operator keys.
	input wire key_up_in,
	input wire key_down_in,
	// LED digits, segment a in bit 0 through dp in bit 7.
	output reg [7:0] led1_seg_out,
	output reg [7:0] led2_seg_out,
	output reg [7:0] led3_seg_out,
	output reg [7:0] led4_seg_out,
	output reg hex_mode_out
);

	localparam PIN_W = 33;

	// Synchroniser stages and key history.
	reg [PIN_W-1:0] pin_meta_r;
	reg [PIN_W-1:0] pin_sync_r;
	reg [1:0] key_prev_r;

	// Software registers.
	reg [1:0] item_r;
	reg hex_mode_r;
	reg hex_mode_nxt;
	reg word_sel_r;
	reg [15:0] cmd_r;
	reg [6:0] inv_r;

	// Decoded terminal states.
	wire [PIN_W-1:0] pin_raw;
	wire fwd_s;
	wire rev_s;
	wire [4:0] gen_s;
	wire y1_s;
	wire y2_s;
	wire alarm_s;
	wire [11:0] opt_in_s;
	wire opt_sel_s;
	wire [7:0] opt_out_s;
	wire [1:0] key_s;
	wire key_event;

	// Words and display patterns.
	wire [6:0] term_inputs;
	wire [15:0] term_in_word;
	wire [15:0] comm_in_word;
	wire [15:0] base_out_word;
	wire [15:0] opt_in_word;
	wire [15:0] opt_out_word;
	reg [15:0] in_word;
	reg [15:0] out_word;
	wire [15:0] hex_word;
	wire [6:0] hex_seg0;
	wire [6:0] hex_seg1;
	wire [6:0] hex_seg2;
	wire [6:0] hex_seg3;
	reg [7:0] led1_nxt;
	reg [7:0] led2_nxt;
	reg [7:0] led3_nxt;
	reg [7:0] led4_nxt;

	// APB decode.
	wire apb_access;
	wire apb_done;
	wire addr_hit;
	reg [31:0] rd_data;
	reg rd_hit;

	// All pins arrive from outside the clock domain in one vector.
	assign pin_raw = {key_down_in, key_up_in, option_card_outputs_in,
		option_card_select_in, option_card_inputs_in,
		alarm_relay_contact_in, second_transistor_output_in,
		first_transistor_output_in, general_digital_inputs_in,
		reverse_run_input_in, forward_run_input_in};

	// Two stages per pin; only the second stage feeds any logic.
	always @(posedge clk_sys_in)
	begin
		if (!nrst_in)
		begin
			pin_meta_r <= {PIN_W{1'b0}};
			pin_sync_r <= {PIN_W{1'b0}};
		end
		else
		begin
			pin_meta_r <= pin_raw;
			pin_sync_r <= pin_meta_r;
		end
	end

	// Unpack the synchronised pins.
	assign fwd_s = pin_sync_r[0];
	assign rev_s = pin_sync_r[1];
	assign gen_s = pin_sync_r[6:2];
	assign y1_s = pin_sync_r[7];
	assign y2_s = pin_sync_r[8];
	assign alarm_s = pin_sync_r[9];
	assign opt_in_s = pin_sync_r[21:10];
	assign opt_sel_s = pin_sync_r[22];
	assign opt_out_s = pin_sync_r[30:23];
	assign key_s = pin_sync_r[32:31];

	// A key press is the rising edge of either key.
	always @(posedge clk_sys_in)
	begin
		if (!nrst_in)
			key_prev_r <= 2'h0;
		else
			key_prev_r <= key_s;
	end

	assign key_event = |(key_s & ~key_prev_r);

	// Terminal inputs pass through the inversion mask; commands do not.
	assign term_inputs = {gen_s, rev_s, fwd_s} ^ inv_r;

	// Input word of the local terminals.
	assign term_in_word = {9'h000, term_inputs};

	// Communicated commands in normal logic, unused bits forced low.
	assign comm_in_word = cmd_r & `IOSLD_CMD_MASK;

	// Output word: transistor outputs low, alarm contact at bit 8.
	assign base_out_word = {7'h00, alarm_s, 6'h00, y2_s, y1_s};

	// Option card words.
	assign opt_in_word = {3'h0, opt_sel_s, opt_in_s};
	assign opt_out_word = {8'h00, opt_out_s};

	// Pick the words of the item on show.
	always @*
	begin
		in_word = term_in_word;
		out_word = base_out_word;
		case (item_r)
			`IOSLD_ITEM_COMM:
			begin
				in_word = comm_in_word;
				out_word = base_out_word;
			end
			`IOSLD_ITEM_OPT:
			begin
				in_word = opt_in_word;
				out_word = opt_out_word;
			end
			default:
			begin
				in_word = term_in_word;
				out_word = base_out_word;
			end
		endcase
	end

	// Hex mode shows one word; software picks input or output.
	assign hex_word = word_sel_r ? out_word : in_word;

	// One decoder per digit, led1 carries the least significant nibble.
	iosld_hex7seg u_hex0 (
		.nibble_in(hex_word[3:0]),
		.seg_out(hex_seg0)
	);

	iosld_hex7seg u_hex1 (
		.nibble_in(hex_word[7:4]),
		.seg_out(hex_seg1)
	);

	iosld_hex7seg u_hex2 (
		.nibble_in(hex_word[11:8]),
		.seg_out(hex_seg2)
	);

	iosld_hex7seg u_hex3 (
		.nibble_in(hex_word[15:12]),
		.seg_out(hex_seg3)
	);

	// Segment patterns; segments without a terminal stay dark except segment g while dashes show.
	always @*
	begin
		led1_nxt = 8'h00;
		led2_nxt = 8'h00;
		led3_nxt = 8'h00;
		led4_nxt = 8'h00;
		if (hex_mode_r)
		begin
			led1_nxt = {1'b0, hex_seg0};
			led2_nxt = {1'b0, hex_seg1};
			led3_nxt = {1'b0, hex_seg2};
			led4_nxt = {1'b0, hex_seg3};
		end
		else if (item_r == `IOSLD_ITEM_OPT)
		begin
			led1_nxt = opt_in_s[7:0];
			led2_nxt = {3'h0, opt_sel_s, opt_in_s[11:8]};
			led3_nxt = opt_out_s;
			led4_nxt = 8'h00;
		end
		else
		begin
			led1_nxt = {1'b0, in_word[6:0]};
			led2_nxt = {in_word[`IOSLD_BIT_RST], in_word[`IOSLD_BIT_XR],
				in_word[`IOSLD_BIT_XF], 5'h00};
			led3_nxt = {6'h00, out_word[`IOSLD_BIT_Y2],
				out_word[`IOSLD_BIT_Y1]};
			led4_nxt = {7'h00, out_word[`IOSLD_BIT_ALARM]};
			// The dash pattern is laid over the outputs so they stay visible.
			if (in_word == 16'h0000)
			begin
				led1_nxt = led1_nxt | `IOSLD_SEG_DASH;
				led2_nxt = led2_nxt | `IOSLD_SEG_DASH;
				led3_nxt = led3_nxt | `IOSLD_SEG_DASH;
				led4_nxt = led4_nxt | `IOSLD_SEG_DASH;
			end
		end
	end

	// Every digit is registered so the pins never glitch.
	always @(posedge clk_sys_in)
	begin
		if (!nrst_in)
		begin
			led1_seg_out <= 8'h00;
			led2_seg_out <= 8'h00;
			led3_seg_out <= 8'h00;
			led4_seg_out <= 8'h00;
			hex_mode_out <= `IOSLD_HEX_RST;
		end
		else
		begin
			led1_seg_out <= led1_nxt;
			led2_seg_out <= led2_nxt;
			led3_seg_out <= led3_nxt;
			led4_seg_out <= led4_nxt;
			hex_mode_out <= hex_mode_r;
		end
	end

	// One wait state: pready rises in the second access cycle.
	assign apb_access = psel_in & penable_in;
	assign apb_done = apb_access & pready_out;

	// Read mux; an unknown address answers zero with an error.
	always @*
	begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		case (paddr_in)
			`IOSLD_OFF_CTRL:
				rd_data = {28'h0000000, word_sel_r, hex_mode_r, item_r};
			`IOSLD_OFF_CMD:
				rd_data = {16'h0000, cmd_r};
			`IOSLD_OFF_INV:
				rd_data = {25'h0000000, inv_r};
			`IOSLD_OFF_IN_WORD:
				rd_data = {16'h0000, in_word};
			`IOSLD_OFF_OUT_WORD:
				rd_data = {16'h0000, out_word};
			`IOSLD_OFF_DISP:
				rd_data = {led4_seg_out, led3_seg_out, led2_seg_out,
					led1_seg_out};
			default:
			begin
				rd_data = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	assign addr_hit = rd_hit;

	// Bus answer registers.
	always @(posedge clk_sys_in)
	begin
		if (!nrst_in)
		begin
			pready_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end
		else if (apb_access && !pready_out)
		begin
			pready_out <= 1'b1;
			prdata_out <= pwrite_in ? 32'h0000_0000 : rd_data;
			pslverr_out <= ~addr_hit;
		end
		else
		begin
			pready_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end
	end

	// A key press beats a simultaneous software write of the mode bit.
	always @*
	begin
		hex_mode_nxt = hex_mode_r;
		if (apb_done && pwrite_in && paddr_in == `IOSLD_OFF_CTRL)
			hex_mode_nxt = pwdata_in[`IOSLD_CTRL_HEX_BIT];
		if (key_event)
			hex_mode_nxt = ~hex_mode_r;
	end

	// Writable registers change at the completing edge; the mode bit also flips on a key press.
	always @(posedge clk_sys_in)
	begin
		if (!nrst_in)
		begin
			item_r <= `IOSLD_ITEM_RST;
			hex_mode_r <= `IOSLD_HEX_RST;
			word_sel_r <= `IOSLD_WSEL_RST;
			cmd_r <= `IOSLD_CMD_RST;
			inv_r <= `IOSLD_INV_RST;
		end
		else
		begin
			hex_mode_r <= hex_mode_nxt;
			if (apb_done && pwrite_in)
			begin
				case (paddr_in)
					`IOSLD_OFF_CTRL:
					begin
						item_r <= pwdata_in[`IOSLD_CTRL_ITEM_MSB:
							`IOSLD_CTRL_ITEM_LSB];
						word_sel_r <= pwdata_in[`IOSLD_CTRL_WSEL_BIT];
					end
					`IOSLD_OFF_CMD:
						cmd_r <= pwdata_in[15:0];
					`IOSLD_OFF_INV:
						inv_r <= pwdata_in[6:0];
					default:
						cmd_r <= cmd_r;
				endcase
			end
		end
	end

endmodule

// ---- iosld_defines.vh ----
// Contract
// - Segment mode: rightmost digit a-g show forward, reverse, general inputs one-five.
// - Segment mode: third digit a/b lit while first/second transistor output conducts.
// - Segment mode: leftmost digit a lit while alarm common-to-open contact closed.
// - All terminal inputs off: segment g lit on all four digits (dashes).
// - Hex mode: 16-bit word, unassigned bits zero, leftmost digit is top nibble.
// - Input word: forward bit 0, reverse bit 1, general inputs bits 2-6.
// - Output word: first transistor output bit 0, second bit 1.
// - Output word: alarm relay contact state at bit 8.
// - Comm control: commands at input bits 13-15, shown on second digit f,g,dp.
// - Comm control: displayed inputs come from the received operation command word.
// - Comm control: command bits shown in normal logic, no input inversion.
// - Option card: inputs, select and outputs mapped onto digits one to three.
// - Option word: inputs bits 0-11, select bit 12; outputs bits 0-7.
// - Up or down key toggles segment and hex mode on digital items.
`ifndef IOSLD_DEFINES_VH
`define IOSLD_DEFINES_VH

// Register byte offsets on the APB slave.
`define IOSLD_OFF_CTRL 8'h00
`define IOSLD_OFF_CMD 8'h04
`define IOSLD_OFF_INV 8'h08
`define IOSLD_OFF_IN_WORD 8'h0c
`define IOSLD_OFF_OUT_WORD 8'h10
`define IOSLD_OFF_DISP 8'h14

// Control register fields.
`define IOSLD_CTRL_ITEM_LSB 0
`define IOSLD_CTRL_ITEM_MSB 1
`define IOSLD_CTRL_HEX_BIT 2
`define IOSLD_CTRL_WSEL_BIT 3

// Display item codes.
`define IOSLD_ITEM_TERM 2'h0
`define IOSLD_ITEM_COMM 2'h1
`define IOSLD_ITEM_OPT 2'h2

// Reset values.
`define IOSLD_ITEM_RST 2'h0
`define IOSLD_HEX_RST 1'b0
`define IOSLD_WSEL_RST 1'b0
`define IOSLD_CMD_RST 16'h0000
`define IOSLD_INV_RST 7'h00

// Word bit positions.
`define IOSLD_BIT_FWD 0
`define IOSLD_BIT_REV 1
`define IOSLD_BIT_GEN_LSB 2
`define IOSLD_BIT_GEN_MSB 6
`define IOSLD_BIT_Y1 0
`define IOSLD_BIT_Y2 1
`define IOSLD_BIT_ALARM 8
`define IOSLD_BIT_XF 13
`define IOSLD_BIT_XR 14
`define IOSLD_BIT_RST 15
`define IOSLD_BIT_SEL 12

// Command word bits that carry a meaning; the rest are zero in the input word.
`define IOSLD_CMD_MASK 16'he07f

// Segment g alone, the dash pattern.
`define IOSLD_SEG_DASH 8'h40

`endif

// ---- iosld_hex7seg.v ----
// Hex digit to seven segments, segment a in bit 0 through g in bit 6.
module iosld_hex7seg (
	// Nibble to show.
	input wire [3:0] nibble_in,
	// Segment pattern, high lights the segment.
	output reg [6:0] seg_out
);

	// Lower-case b and d keep them distinct from 8 and 0.
	always @*
	begin
		case (nibble_in)
			4'h0: seg_out = 7'h3f;
			4'h1: seg_out = 7'h06;
			4'h2: seg_out = 7'h5b;
			4'h3: seg_out = 7'h4f;
			4'h4: seg_out = 7'h66;
			4'h5: seg_out = 7'h6d;
			4'h6: seg_out = 7'h7d;
			4'h7: seg_out = 7'h07;
			4'h8: seg_out = 7'h7f;
			4'h9: seg_out = 7'h6f;
			4'ha: seg_out = 7'h77;
			4'hb: seg_out = 7'h7c;
			4'hc: seg_out = 7'h39;
			4'hd: seg_out = 7'h5e;
			4'he: seg_out = 7'h79;
			default: seg_out = 7'h71;
		endcase
	end

endmodule

// ---- iosld_checker.sv ----
`include "iosld_defines.vh"

// Watches the display and the bus answer of the status formatter.
module iosld_checker #(
	parameter ADDR_W = 8
) (
	// Clock, reset and bus.
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	// Pins, keys and display.
	input wire logic forward_run_input_in,
	input wire logic reverse_run_input_in,
	input wire logic [4:0] general_digital_inputs_in,
	input wire logic first_transistor_output_in,
	input wire logic second_transistor_output_in,
	input wire logic alarm_relay_contact_in,
	input wire logic [11:0] option_card_inputs_in,
	input wire logic option_card_select_in,
	input wire logic [7:0] option_card_outputs_in,
	input wire logic key_up_in,
	input wire logic [7:0] led1_seg_out,
	input wire logic [7:0] led2_seg_out,
	input wire logic [7:0] led3_seg_out,
	input wire logic [7:0] led4_seg_out,
	input wire logic hex_mode_out
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam [127:0] HEX = 128'h71795e397c776f7f077d6d664f5b063f;
	logic [30:0] p1, p2, p3;
	logic [1:0] item_r;
	logic wsel_r, wr, ok, z, cz;
	logic [6:0] inv_r, tw;
	logic [15:0] cmd_r, cw, hw;
	logic [31:0] et, eh, disp;

	function automatic logic [7:0] h(input logic [3:0] n);
		return HEX[n*8+:8];
	endfunction

	// Pins cross two synchronisers and an output flop, hence three stages.
	// The settle count restarts on any write or mode flip.
	always_ff @(posedge clk_sys_in)
	begin
		p1 <= {option_card_outputs_in, option_card_select_in,
			option_card_inputs_in, alarm_relay_contact_in,
			second_transistor_output_in, first_transistor_output_in,
			general_digital_inputs_in, reverse_run_input_in,
			forward_run_input_in};
		p2 <= p1;
		p3 <= p2;
		if (!nrst_in)
		begin
			item_r <= 2'h0;
			wsel_r <= 1'b0;
			inv_r <= 7'h00;
			cmd_r <= 16'h0000;
			ok <= 1'b0;
		end
		else
		begin
			ok <= !wr && !$changed(hex_mode_out) && (ok || $past(!wr, 5));
			if (wr && paddr_in == `IOSLD_OFF_CTRL)
			begin
				item_r <= pwdata_in[1:0];
				wsel_r <= pwdata_in[3];
			end
			if (wr && paddr_in == `IOSLD_OFF_INV)
				inv_r <= pwdata_in[6:0];
			if (wr && paddr_in == `IOSLD_OFF_CMD)
				cmd_r <= pwdata_in[15:0];
		end
	end

	// Expected pictures, worked out from the pins three edges back.
	always_comb
	begin
		wr = psel_in & penable_in & pready_out & pwrite_in;
		tw = p3[6:0] ^ inv_r;
		z = tw == 7'h00;
		cw = cmd_r & `IOSLD_CMD_MASK;
		cz = cw == 16'h0000;
		hw = wsel_r ? {7'h00, p3[9], 6'h00, p3[8:7]} : {9'h000, tw};
		// The command item swaps only the input word; the card swaps both.
		if (item_r == 2'h1 && !wsel_r)
			hw = cw;
		if (item_r == 2'h2)
			hw = wsel_r ? {8'h00, p3[30:23]} : {3'h0, p3[22:10]};
		et = {1'b0, z, 5'h00, p3[9], 1'b0, z, 4'h0, p3[8:7],
			1'b0, z, 6'h00, 1'b0, tw[6] | z, tw[5:0]};
		eh = {h(hw[15:12]), h(hw[11:8]), h(hw[7:4]), h(hw[3:0])};
		disp = {led4_seg_out, led3_seg_out, led2_seg_out, led1_seg_out};
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);

	chk_term_disp: assert property (
		ok && !hex_mode_out && (item_r == 2'h0 || item_r == 2'h3)
		|-> disp == et) else $error("terminal segments wrong");
	chk_comm_disp: assert property (
		ok && !hex_mode_out && item_r == 2'h1 |-> disp ==
		{1'b0, cz, 5'h00, p3[9], 1'b0, cz, 4'h0, p3[8:7], cw[15],
		cw[14] | cz, cw[13], 6'h00, cw[6] | cz, cw[5:0]})
		else $error("command segments wrong");
	chk_opt_disp: assert property (
		ok && !hex_mode_out && item_r == 2'h2
		|-> disp == {8'h00, p3[30:23], 3'h0, p3[22:10]})
		else $error("option card segments wrong");
	chk_hex_disp: assert property (
		ok && hex_mode_out
		|-> disp == eh) else $error("hex digits wrong");
	chk_key_toggle: assert property (
		$rose(key_up_in) |-> ##[2:6] $changed(hex_mode_out))
		else $error("key did not flip the mode");
	chk_apb_wait: assert property (
		psel_in && $rose(penable_in) |-> !pready_out ##1 pready_out)
		else $error("ready not in second access cycle");
	chk_apb_err: assert property (pready_out |-> pslverr_out ==
		(paddr_in > `IOSLD_OFF_DISP || paddr_in[1:0] != 2'h0))
		else $error("slave error flag wrong");
	chk_rdata_idle: assert property (
		!pready_out |-> prdata_out == 32'h0 && !pslverr_out)
		else $error("bus answer outside ready");
endmodule

// ---- iosld_term_model.sv ----
// Terminal strip and option card seen from the block, high while closed.
module iosld_term_model (
	// Clock and the pattern chosen by the bench.
	input wire logic clk_sys_in,
	input wire logic [30:0] pat_in,
	// Contact states toward the block.
	output logic forward_run_input_in,
	output logic reverse_run_input_in,
	output logic [4:0] general_digital_inputs_in,
	output logic first_transistor_output_in,
	output logic second_transistor_output_in,
	output logic alarm_relay_contact_in,
	output logic [11:0] option_card_inputs_in,
	output logic option_card_select_in,
	output logic [7:0] option_card_outputs_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Contacts move just after an edge, as a real strip would settle.
	always @(posedge clk_sys_in)
		{option_card_outputs_in, option_card_select_in,
			option_card_inputs_in, alarm_relay_contact_in,
			second_transistor_output_in, first_transistor_output_in,
			general_digital_inputs_in, reverse_run_input_in,
			forward_run_input_in} <= pat_in;
endmodule

// ---- iosld_top_tb.sv ----
`include "iosld_defines.vh"

module iosld_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in, nrst_in, psel_in, penable_in, pwrite_in, err;
	logic pready_out, pslverr_out, key_up_in, key_down_in, hex_mode_out;
	logic [7:0] paddr_in, led1_seg_out, led2_seg_out;
	logic [7:0] led3_seg_out, led4_seg_out, option_card_outputs_in;
	logic [31:0] pwdata_in, prdata_out, rd;
	logic forward_run_input_in, reverse_run_input_in;
	logic first_transistor_output_in, second_transistor_output_in;
	logic alarm_relay_contact_in, option_card_select_in;
	logic [4:0] general_digital_inputs_in;
	logic [11:0] option_card_inputs_in;
	logic [30:0] pat_in, pat;
	logic [15:0] rs;
	logic [6:0] inv;
	int fails, compares;

	iosld_top iosld_top_i (.*);
	iosld_term_model iosld_term_model_i (.*);

	initial
	begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask

	task automatic chk(input logic [31:0] seen, exp, input string what);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [15:0] lf(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Input word of the item on show; commands bypass the inversion mask.
	function automatic logic [31:0] exp_in(input logic [1:0] it,
		input logic [30:0] p, input logic [6:0] v, input logic [15:0] m);
		if (it == 2'h1)
			return {16'h0, m & `IOSLD_CMD_MASK};
		if (it == 2'h2)
			return {19'h0, p[22:10]};
		return {25'h0, p[6:0] ^ v};
	endfunction

	// Output word of the item on show.
	function automatic logic [31:0] exp_out(input logic [1:0] it,
		input logic [30:0] p);
		if (it == 2'h2)
			return {24'h0, p[30:23]};
		return {23'h0, p[9], 6'h0, p[8:7]};
	endfunction

	// Segment picture in segment mode, led4 in the top byte.
	function automatic logic [31:0] exp_seg(input logic [1:0] it,
		input logic [30:0] p, input logic [6:0] v, input logic [15:0] m);
		logic [15:0] w;
		logic z;
		if (it == 2'h2)
			return {8'h00, p[30:23], 3'h0, p[22:10]};
		w = it == 2'h1 ? m & `IOSLD_CMD_MASK : {9'h0, p[6:0] ^ v};
		z = w == 16'h0;
		return {1'b0, z, 5'h0, p[9], 1'b0, z, 4'h0, p[8:7],
			w[15], w[14] | z, w[13], 6'h0, w[6] | z, w[5:0]};
	endfunction

	// One bus transfer; an idle edge first keeps strobes from doubling.
	task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
		@(posedge clk_sys_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_sys_in);
		penable_in <= 1'b1;
		// Only the watchdog ends a wait for the answer.
		do
			@(posedge clk_sys_in);
		while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic finish_test;
		$display("Compares %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		cyc(20000);
		fails++;
		finish_test();
	end

	initial
	begin
		{psel_in, penable_in, pwrite_in, key_up_in, key_down_in} = 5'h00;
		paddr_in = 8'h00;
		pwdata_in = 32'h0;
		pat_in = 31'h0;
		rs = 16'h6ce0;
		nrst_in = 1'b0;
		cyc(16);
		nrst_in <= 1'b1;
		// Reset values, the dash picture and the refused places.
		apb(0, `IOSLD_OFF_CTRL, 0);
		chk(rd, 32'h0, "ctrl");
		apb(0, `IOSLD_OFF_INV, 0);
		chk(rd, 32'h0, "inv");
		apb(0, `IOSLD_OFF_DISP, 0);
		chk(rd, 32'h40404040, "dash");
		apb(1, `IOSLD_OFF_IN_WORD, 32'hffff);
		chk({31'h0, err}, 32'h0, "ro write");
		apb(0, 8'h18, 0);
		chk({rd[30:0], err}, 32'h1, "unmapped");
		apb(1, `IOSLD_OFF_CMD, 32'hffffffff);
		apb(0, `IOSLD_OFF_CMD, 0);
		chk(rd, 32'h0000ffff, "cmd");
		// Every item, mode and word select with random contacts.
		for (int i = 0; i < 16; i++)
		begin
			rs = lf(rs);
			inv = rs[6:0];
			apb(1, `IOSLD_OFF_INV, {25'h0, inv});
			rs = lf(rs);
			apb(1, `IOSLD_OFF_CMD, {16'h0, rs});
			pat = {rs[14:0], lf(rs)};
			// First pass cancels every input through the mask: dashes.
			if (i == 0)
				pat[6:0] = inv;
			pat_in <= pat;
			apb(1, `IOSLD_OFF_CTRL, {28'h0, i[3:0]});
			cyc(8);
			chk({31'h0, hex_mode_out}, {31'h0, i[2]}, "hex");
			apb(0, `IOSLD_OFF_OUT_WORD, 0);
			chk(rd, exp_out(i[1:0], pat), "out");
			apb(0, `IOSLD_OFF_IN_WORD, 0);
			chk(rd, exp_in(i[1:0], pat, inv, rs), "in");
			if (!i[2])
			begin
				apb(0, `IOSLD_OFF_DISP, 0);
				chk(rd, exp_seg(i[1:0], pat, inv, rs), "seg");
			end
		end
		// Each key flips the mode once.
		apb(1, `IOSLD_OFF_CTRL, 0);
		key_up_in <= 1'b1;
		cyc(2);
		key_up_in <= 1'b0;
		cyc(8);
		chk({31'h0, hex_mode_out}, 32'h1, "key up");
		key_down_in <= 1'b1;
		cyc(2);
		key_down_in <= 1'b0;
		cyc(8);
		chk({31'h0, hex_mode_out}, 32'h0, "key down");
		finish_test();
	end
endmodule

bind iosld_top iosld_checker #(.ADDR_W(ADDR_W)) iosld_checker_i (.*);
